// *** shared/gpt_pkg.sv ***
// Purpose: constants and types shared by the general purpose timer block
// Assumes: 20 MHz aclk, one machine cycle every MC_DIV clocks
// Notes:   registers are one aligned 32-bit word each
package gpt_pkg;
  // ==========================================================================
  // timing
  localparam int          MC_DIV       = 12;
  localparam logic [3:0]  MC_LAST      = 4'hB;
  // ==========================================================================
  // register byte offsets
  localparam logic [7:0]  A_CTRL       = 8'h00;
  localparam logic [7:0]  A_CNT0       = 8'h04;
  localparam logic [7:0]  A_CNT1       = 8'h08;
  localparam logic [7:0]  A_CNT2       = 8'h0C;
  localparam logic [7:0]  A_RLD2       = 8'h10;
  localparam logic [7:0]  A_CAP2       = 8'h14;
  localparam logic [7:0]  A_STAT       = 8'h18;
  localparam logic [7:0]  A_CLR        = 8'h1C;
  localparam logic [7:0]  A_IEN        = 8'h20;
  // ==========================================================================
  // control fields
  localparam int          F_RUN        = 0;  // bits 2:0 run per unit
  localparam int          F_CNT        = 4;  // bits 6:4 counter select
  localparam int          F_MODE       = 8;  // bits 9:8 third unit mode
  localparam int          F_DOWN       = 10;
  localparam int          F_OEN        = 11;
  localparam int          F_CAPNOW     = 12; // write 1 pulses a capture
  localparam logic [31:0] CTRL_RST     = 32'h0000_0000;
  // status bits: 2:0 overflow per unit, 3 capture done
  localparam int          NSTAT        = 4;
  localparam int          S_CAP        = 3;
  localparam logic [1:0]  RESP_OK      = 2'h0;
  localparam logic [1:0]  RESP_ERR     = 2'h2;

  typedef enum logic [1:0] {
    GPT_M_FREE   = 2'h0,
    GPT_M_CAP    = 2'h1,
    GPT_M_RELOAD = 2'h3
  } gpt_mode_e;

  typedef struct packed {
    logic        run;
    logic        cnt_sel;
    logic        down;
    logic        reload;
  } gpt_cfg_s;
endpackage : gpt_pkg

// *** hdl/gpt_unit.sv ***
// Purpose: one 16-bit timer/counter unit
// Assumes: mc_tick is a one-clock pulse per machine cycle
// Notes:   reload and down only used by the third unit
module gpt_unit (
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic             mc_tick,
  input  wire gpt_pkg::gpt_cfg_s cfg,
  input  wire logic             ev_in,
  input  wire logic             wr_en,
  input  wire logic [15:0]      wr_data,
  input  wire logic [15:0]      reload_val,
  output logic [15:0]           count,
  output logic                  wrap
);
  typedef struct packed {
    logic [15:0] cnt;
    logic        smp;
    logic        wrap;
  } gpt_ust_s;

  gpt_ust_s st_r;
  gpt_ust_s st_nxt;
  logic     step;

  assign count = st_r.cnt;
  assign wrap  = st_r.wrap;

  // ==========================================================================
  // counting
  always_comb begin
    st_nxt      = st_r;
    st_nxt.wrap = 1'b0;
    if (mc_tick) begin
      st_nxt.smp = ev_in;                                   // RL5
    end
    // fall seen as old sample high, new sample low; count shows next cycle
    step = cfg.run && mc_tick && (cfg.cnt_sel ? (st_r.smp && !ev_in) : 1'b1); // RL3 RL4 RL6 RL7 RL8
    if (wr_en) begin
      st_nxt.cnt = wr_data;
    end else if (step) begin
      if (cfg.down) begin                                   // RL12
        if (st_r.cnt == 16'h0000) begin
          st_nxt.cnt  = cfg.reload ? reload_val : 16'hFFFF;
          st_nxt.wrap = 1'b1;
        end else begin
          st_nxt.cnt = st_r.cnt - 16'h0001;
        end
      end else if (st_r.cnt == 16'hFFFF) begin
        st_nxt.cnt  = cfg.reload ? reload_val : 16'h0000;   // RL12
        st_nxt.wrap = 1'b1;                                 // RL14
      end else begin
        st_nxt.cnt = st_r.cnt + 16'h0001;                   // RL1 RL10
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
endmodule : gpt_unit

// *** hdl/gpt_top.sv ***
// Purpose: three general purpose 16-bit timers behind an AXI4-Lite slave
// Assumes: event inputs synchronous to aclk
// Notes:   one read and one write under way at a time
//
// Notes on behaviour
// RL1: three independent 16-bit timer or counter units
// RL2: each unit can raise periodic interrupts
// RL3: timer mode counts once per machine cycle
// RL4: counter mode counts event input falling edges
// RL5: sample event input once per machine cycle
// RL6: new count visible in following machine cycle
// RL7: edge needs two machine cycles to recognise
// RL8: any event input duty cycle accepted
// RL9: source holds each level one machine cycle
// RL10: third unit always a full 16-bit counter
// RL11: third unit captures running count for software
// RL12: third unit auto-reload, up or down count
// RL13: third unit drives a timer output signal
// RL14: wrap all ones to zero sets overflow
module gpt_top (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        event_input_first,
  input  wire logic        event_input_second,
  input  wire logic        event_input_third,
  output logic             timer_out,
  output logic             irq,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);
  typedef struct packed {
    logic [3:0]                div;
    logic [31:0]               ctrl;
    logic [15:0]               rld;
    logic [15:0]               cap;
    logic [gpt_pkg::NSTAT-1:0] stat;
    logic [gpt_pkg::NSTAT-1:0] ien;
    logic                      tout;
    logic                      aw_h;
    logic [7:0]                awa;
    logic                      w_h;
    logic [31:0]               wd;
    logic [3:0]                ws;
    logic                      bv;
    logic [1:0]                br;
    logic                      rv;
    logic [31:0]               rd;
    logic [1:0]                rr;
  } gpt_st_s;

  gpt_st_s           st_r;
  gpt_st_s           st_nxt;
  logic              mc_tick;
  logic [2:0]        ev;
  logic [2:0]        wrap;
  logic [2:0]        cnt_we;
  logic [15:0]       cnt [3];
  gpt_pkg::gpt_cfg_s cfg [3];
  logic              wr_go;
  logic [15:0]       wr16;
  logic [31:0]       wr32;
  gpt_pkg::gpt_mode_e mode;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] s);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) begin
        r[i*8 +: 8] = d[i*8 +: 8];
      end
    end
    return r;
  endfunction : merge

  assign mc_tick = (st_r.div == gpt_pkg::MC_LAST);
  assign ev      = {event_input_third, event_input_second, event_input_first};
  assign mode    = gpt_pkg::gpt_mode_e'(st_r.ctrl[gpt_pkg::F_MODE +: 2]);
  assign wr_go   = st_r.aw_h && st_r.w_h && !st_r.bv;
  // unstrobed lanes read as zero
  assign wr32    = merge(32'h0000_0000, st_r.wd, st_r.ws);
  assign wr16    = wr32[15:0];

  // ==========================================================================
  // units
  for (genvar u = 0; u < 3; u++) begin : g_unit
    assign cfg[u].run     = st_r.ctrl[gpt_pkg::F_RUN + u];
    assign cfg[u].cnt_sel = st_r.ctrl[gpt_pkg::F_CNT + u];
    assign cfg[u].down    = (u == 2) && (mode == gpt_pkg::GPT_M_RELOAD) && st_r.ctrl[gpt_pkg::F_DOWN]; // RL12
    assign cfg[u].reload  = (u == 2) && (mode == gpt_pkg::GPT_M_RELOAD);                               // RL12
    assign cnt_we[u]      = wr_go && (st_r.awa == gpt_pkg::A_CNT0 + 8'(4 * u));
    gpt_unit u_unit (
      .aclk       (aclk),
      .aresetn    (aresetn),
      .mc_tick    (mc_tick),
      .cfg        (cfg[u]),
      .ev_in      (ev[u]),
      .wr_en      (cnt_we[u]),
      .wr_data    (wr16),
      .reload_val (st_r.rld),
      .count      (cnt[u]),
      .wrap       (wrap[u])
    );
  end

  assign timer_out     = st_r.tout;
  assign irq           = |(st_r.stat & st_r.ien);   // RL2
  assign s_axi_awready = !st_r.aw_h;
  assign s_axi_wready  = !st_r.w_h;
  assign s_axi_bvalid  = st_r.bv;
  assign s_axi_bresp   = st_r.br;
  assign s_axi_arready = !st_r.rv;
  assign s_axi_rvalid  = st_r.rv;
  assign s_axi_rdata   = st_r.rd;
  assign s_axi_rresp   = st_r.rr;

  // ==========================================================================
  // control and bus
  always_comb begin
    logic       cap_go;
    logic [3:0] clr;
    st_nxt = st_r;
    cap_go = 1'b0;
    clr    = 4'h0;
    st_nxt.div = mc_tick ? 4'h0 : st_r.div + 4'h1;
    // write channels taken in either order
    if (s_axi_awvalid && !st_r.aw_h) begin
      st_nxt.aw_h = 1'b1;
      st_nxt.awa  = s_axi_awaddr;
    end
    if (s_axi_wvalid && !st_r.w_h) begin
      st_nxt.w_h = 1'b1;
      st_nxt.wd  = s_axi_wdata;
      st_nxt.ws  = s_axi_wstrb;
    end
    if (wr_go) begin
      st_nxt.aw_h = 1'b0;
      st_nxt.w_h  = 1'b0;
      st_nxt.bv   = 1'b1;
      st_nxt.br   = gpt_pkg::RESP_OK;
      case (st_r.awa)
        gpt_pkg::A_CTRL: begin
          st_nxt.ctrl = merge(st_r.ctrl, st_r.wd, st_r.ws);
          st_nxt.ctrl[gpt_pkg::F_CAPNOW] = 1'b0;
          cap_go = st_r.ws[1] && st_r.wd[gpt_pkg::F_CAPNOW];
        end
        gpt_pkg::A_RLD2: st_nxt.rld = wr16;
        gpt_pkg::A_CLR:  clr = st_r.wd[gpt_pkg::NSTAT-1:0] & {4{st_r.ws[0]}};
        gpt_pkg::A_IEN:  if (st_r.ws[0]) st_nxt.ien = st_r.wd[gpt_pkg::NSTAT-1:0];
        gpt_pkg::A_CNT0, gpt_pkg::A_CNT1, gpt_pkg::A_CNT2: ;
        default:         st_nxt.br = gpt_pkg::RESP_ERR;
      endcase
    end
    if (st_r.bv && s_axi_bready) begin
      st_nxt.bv = 1'b0;
    end
    if (s_axi_arvalid && !st_r.rv) begin
      st_nxt.rv = 1'b1;
      st_nxt.rr = gpt_pkg::RESP_OK;
      case (s_axi_araddr)
        gpt_pkg::A_CTRL: st_nxt.rd = st_r.ctrl;
        gpt_pkg::A_CNT0: st_nxt.rd = {16'h0000, cnt[0]};
        gpt_pkg::A_CNT1: st_nxt.rd = {16'h0000, cnt[1]};
        gpt_pkg::A_CNT2: st_nxt.rd = {16'h0000, cnt[2]};
        gpt_pkg::A_RLD2: st_nxt.rd = {16'h0000, st_r.rld};
        gpt_pkg::A_CAP2: st_nxt.rd = {16'h0000, st_r.cap};  // RL11
        gpt_pkg::A_STAT: st_nxt.rd = {28'h0000000, st_r.stat};
        gpt_pkg::A_IEN:  st_nxt.rd = {28'h0000000, st_r.ien};
        gpt_pkg::A_CLR:  st_nxt.rd = 32'h0000_0000;
        default: begin
          st_nxt.rd = 32'h0000_0000;
          st_nxt.rr = gpt_pkg::RESP_ERR;
        end
      endcase
    end else if (st_r.rv && s_axi_rready) begin
      st_nxt.rv = 1'b0;
    end
    // capture by software strobe only, keeps the latch free of input glitches
    if (mode == gpt_pkg::GPT_M_CAP && cap_go) begin
      st_nxt.cap = cnt[2];                               // RL11
    end
    // sticky status; a set in the clear cycle wins
    st_nxt.stat = (st_r.stat & ~clr) | {(mode == gpt_pkg::GPT_M_CAP) && cap_go, wrap}; // RL14 RL2
    // toggle output on every wrap of the third unit, gated by its enable
    if (wrap[2] && st_r.ctrl[gpt_pkg::F_OEN]) begin
      st_nxt.tout = !st_r.tout;                          // RL13
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r      <= '0;
      st_r.ctrl <= gpt_pkg::CTRL_RST;
    end else begin
      st_r <= st_nxt;
    end
  end
endmodule : gpt_top

// *** test/gpt_ev_src.sv ***
// Purpose: event source at the three counter inputs
// Assumes: run bits change just after a clock edge
// Notes:   whole pulses only, 24 clocks high then 24 low
module gpt_ev_src (
  input  wire logic       aclk,
  input  wire logic [2:0] run,
  output logic      [2:0] ev
);
  timeunit 1ns;
  timeprecision 1ns;
  // ========
  // pulse train
  logic [5:0] ph_r  = 6'h00;
  logic [2:0] act_r = 3'h0;
  always_ff @(posedge aclk) begin
    ph_r <= (ph_r == 6'h2F) ? 6'h00 : ph_r + 6'h01;
    // latched per period so no half pulse
    if (ph_r == 6'h00) act_r <= run;
  end
  // idle high, each level two machine cycles
  assign ev = ~(act_r & {3{ph_r >= 6'h18}});
endmodule : gpt_ev_src

// *** test/gpt_top_assertions.sv ***
// Purpose: port checks for gpt_top
// Assumes: one clock domain
// Notes:   bound at the foot of this file
module gpt_top_chk (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        timer_out,
  input wire logic        irq,
  input wire logic [7:0]  s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [7:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid
);
  // ========
  // properties
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_wr;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rd;
    s_axi_arvalid && s_axi_arready;
  endsequence
  // both channels taken, held a cycle, response registered one cycle later
  chk_wr_resp: assert property (s_wr |-> ##2 s_axi_bvalid) else $error("no write response");
  chk_rd_resp: assert property (s_rd |=> s_axi_rvalid) else $error("no read response");
  chk_ar_busy: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read taken while busy");
  chk_aw_busy: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready) else $error("write taken while busy");
  chk_b_once: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid) else $error("double response");
  chk_rd_unmap: assert property (s_rd ##0 (s_axi_araddr > 8'h20) |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
  chk_wr_unmap: assert property (s_wr ##0 (s_axi_awaddr > 8'h20) |-> ##2 s_axi_bresp == 2'h2)
    else $error("unmapped write not refused");
  // a wrap lands on a machine cycle, never two in 8 clocks
  chk_out_step: assert property ($changed(timer_out) |=> $stable(timer_out) [*8])
    else $error("timer output toggles too fast");
  chk_irq_mask: assert property (s_wr ##0 (s_axi_awaddr == gpt_pkg::A_IEN && s_axi_wdata == 32'h0) |-> ##2 !irq)
    else $error("masked interrupt still high");
endmodule : gpt_top_chk

bind gpt_top gpt_top_chk i_chk (
  .aclk, .aresetn, .timer_out, .irq, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wdata, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
  .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid
);

// *** test/tb.sv ***
// Purpose: self-checking bench for gpt_top
// Assumes: machine cycle of 12 clocks
// Notes:   bready and rready held high throughout
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  // ========
  // signals
  logic        aclk = 1'h0, aresetn = 1'h0, timer_out, irq;
  logic [2:0]  ev, ev_run = 3'h0;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_arvalid = 1'h0;
  logic        s_axi_bready = 1'h1, s_axi_rready = 1'h1;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
  int          failures = 0, comparisons = 0, cyc = 0;
  gpt_top i_dut (.aclk, .aresetn, .event_input_first(ev[0]), .event_input_second(ev[1]),
    .event_input_third(ev[2]), .timer_out, .irq, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready);
  gpt_ev_src i_src (.aclk, .run(ev_run), .ev);
  initial forever #25 aclk = ~aclk;
  // ========
  // helpers
  task automatic ck(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      failures++;
      $display("ERROR %0t got %h exp %h", $time, g, e);
    end
  endtask : ck
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ta, tw;
    ta = 1'h0;
    tw = 1'h0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) begin s_axi_awvalid <= 1'h0; ta = 1'h1; end
      if (s_axi_wready) begin s_axi_wvalid <= 1'h0; tw = 1'h1; end
    end while (!(ta && tw));
    do @(posedge aclk); while (!s_axi_bvalid);
    rs = s_axi_bresp;
  endtask : wr
  task automatic rdr(input logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'h0;
    do @(posedge aclk); while (!s_axi_rvalid);
    rd = s_axi_rdata;
  endtask : rdr
  task automatic finish_test;
    $display("failures %0d comparisons %0d", failures, comparisons);
    if (failures == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : finish_test
  // ========
  // scenarios
  task automatic t_timer;
    logic [31:0] v;
    rdr(gpt_pkg::A_CTRL);
    ck(rd, gpt_pkg::CTRL_RST);
    ck({timer_out, irq}, 32'h0);
    wr(gpt_pkg::A_CNT0, 32'h0);
    wr(gpt_pkg::A_CTRL, 32'h1);
    rdr(gpt_pkg::A_CNT0);
    v = rd;
    // reads sample exactly 120 clocks apart
    repeat (118) @(posedge aclk);
    rdr(gpt_pkg::A_CNT0);
    ck(rd - v, 32'hA);
  endtask : t_timer
  task automatic t_wrap;
    wr(gpt_pkg::A_CNT1, 32'hFFFF);
    wr(gpt_pkg::A_IEN, 32'h2);
    wr(gpt_pkg::A_CTRL, 32'h2);
    repeat (30) @(posedge aclk);
    rdr(gpt_pkg::A_STAT);
    ck(rd, 32'h2);
    ck(irq, 32'h1);
    wr(gpt_pkg::A_IEN, 32'h0);
    ck(irq, 32'h0);
    wr(gpt_pkg::A_IEN, 32'h2);
    wr(gpt_pkg::A_CLR, 32'h2);
    rdr(gpt_pkg::A_STAT);
    ck(rd, 32'h0);
    ck(irq, 32'h0);
  endtask : t_wrap
  task automatic t_count;
    wr(gpt_pkg::A_CTRL, 32'h0);
    for (int i = 1; i < 4; i++) wr(8'(4 * i), 32'h0);
    wr(gpt_pkg::A_CTRL, 32'h77);
    ev_run <= 3'h7;
    repeat (144) @(posedge aclk);
    ev_run <= 3'h6;
    repeat (96) @(posedge aclk);
    ev_run <= 3'h0;
    repeat (100) @(posedge aclk);
    rdr(gpt_pkg::A_CNT0);
    ck(rd, 32'h3);
    rdr(gpt_pkg::A_CNT1);
    ck(rd, 32'h5);
    rdr(gpt_pkg::A_CNT2);
    ck(rd, 32'h5);
  endtask : t_count
  task automatic t_reload;
    wr(gpt_pkg::A_CTRL, 32'h0);
    wr(gpt_pkg::A_RLD2, 32'hFFF8);
    wr(gpt_pkg::A_CNT2, 32'hFFFE);
    wr(gpt_pkg::A_CLR, 32'hF);
    wr(gpt_pkg::A_CTRL, 32'hB04);
    repeat (40) @(posedge aclk);
    rdr(gpt_pkg::A_CNT2);
    ck({rd[15:4], timer_out}, 32'h1FFF);
    rdr(gpt_pkg::A_STAT);
    ck(rd, 32'h4);
    wr(gpt_pkg::A_CTRL, 32'hF04);
    wr(gpt_pkg::A_CNT2, 32'h1);
    repeat (48) @(posedge aclk);
    rdr(gpt_pkg::A_CNT2);
    ck({rd[15:4], timer_out}, 32'h1FFE);
  endtask : t_reload
  task automatic t_cap;
    wr(gpt_pkg::A_CTRL, 32'h100);
    wr(gpt_pkg::A_CNT2, 32'h1234);
    wr(gpt_pkg::A_CTRL, 32'h1100);
    rdr(gpt_pkg::A_CAP2);
    ck(rd, 32'h1234);
    rdr(gpt_pkg::A_STAT);
    ck(rd[gpt_pkg::S_CAP], 32'h1);
    wr(8'h24, 32'h1);
    ck(rs, gpt_pkg::RESP_ERR);
    rdr(8'h24);
    ck(rd, 32'h0);
    ck(s_axi_rresp, gpt_pkg::RESP_ERR);
  endtask : t_cap
  // ========
  // run
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      failures++;
      $display("ERROR %0t timeout", $time);
      finish_test;
    end
  end
  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    t_timer;
    t_wrap;
    t_count;
    t_reload;
    t_cap;
    finish_test;
  end
endmodule : tb
